// >>> sie_map.svh
// Purpose: Named offsets, field positions, reset values and timing for the indicator encoder.
// Assumes: 10 MHz system clock.
// Notes: Definitions only.
`ifndef SIE_MAP_SVH
`define SIE_MAP_SVH
`define SIE_CLK_NS 100
`define SIE_UNIT_NS 50000000
`define SIE_UNIT_CYC (`SIE_UNIT_NS / `SIE_CLK_NS)
`define SIE_FRAME_LAST 6'd39
`define SIE_FLASH_LEN 6'd4
`define SIE_FLASH2_AT 6'd8
`define SIE_FLASH3_AT 6'd16
`define SIE_BLINK_BIT 2
`define SIE_COL_LAST 2'd2
`define SIE_CHAR_UNITS 5'd10
`define SIE_LONG_UNITS 6'd40
`define SIE_CODE_LAST 4'd4
`define SIE_ADDR_LAST 4'd8
`define SIE_OFF_CTRL 12'h000
`define SIE_OFF_ADDR 12'h004
`define SIE_OFF_IRQ_STAT 12'h008
`define SIE_OFF_IRQ_MASK 12'h00c
`define SIE_OFF_STATE 12'h010
`define SIE_CTRL_EN 0
`define SIE_CTRL_RST 32'h0000_0001
`define SIE_IRQ_BTN 0
`define SIE_IRQ_FAULT 1
`define SIE_IRQ_LINK 2
`define SIE_IRQ_W 3
`define SIE_SEG_BLANK 7'h00
`define SIE_SEG_N 7'h54
`define SIE_SEG_E 7'h79
`define SIE_SEG_F 7'h71
`endif

// >>> sie_pkg.sv
// Purpose: Types shared by the indicator encoder modules.
// Assumes: One-hot state codes from the status sources.
// Notes: Illegal error and drive codes are shown as steady red by the encoder.
package sie_pkg;
	typedef enum logic [4:0] {SIE_RUN_INIT = 5'h01, SIE_RUN_PREOP = 5'h02, SIE_RUN_SAFEOP = 5'h04,
		SIE_RUN_OP = 5'h08, SIE_RUN_BOOT = 5'h10} sie_run_e;
	typedef enum logic [6:0] {SIE_ERR_NONE = 7'h01, SIE_ERR_APP = 7'h02, SIE_ERR_WDOG = 7'h04,
		SIE_ERR_LOCAL = 7'h08, SIE_ERR_CFG = 7'h10, SIE_ERR_BOOT = 7'h20,
		SIE_ERR_RSVD = 7'h40} sie_err_e;
	typedef enum logic [5:0] {SIE_PC_CLOSED = 6'h01, SIE_PC_OPEN = 6'h02, SIE_PC_MANUAL = 6'h04,
		SIE_PC_AN_LOCAL = 6'h08, SIE_PC_AN_REMOTE = 6'h10, SIE_PC_AN_UNKNOWN = 6'h20} sie_port_e;
	typedef enum logic [4:0] {SIE_DRV_OFF = 5'h01, SIE_DRV_RUN = 5'h02, SIE_DRV_WARN = 5'h04,
		SIE_DRV_SAFE = 5'h08, SIE_DRV_FAULT = 5'h10} sie_drive_e;
	typedef enum logic [2:0] {SIE_D_STATUS = 3'h1, SIE_D_CODE = 3'h2, SIE_D_ADDR = 3'h4} sie_disp_e;
	typedef struct packed {
		logic tick;
		logic blink;
		logic single;
		logic dbl;
		logic triple;
		logic flicker;
		logic [1:0] colour;
	} sie_pat_s;
	typedef struct packed {
		sie_run_e run;
		sie_err_e err;
	} sie_bus_state_s;
	typedef struct packed {
		logic link;
		logic act;
		sie_port_e cond;
	} sie_port_s;
	typedef struct packed {
		logic valid;
		logic warn;
		logic use_e;
		logic [11:0] digits;
	} sie_code_s;
	typedef struct packed {
		logic green;
		logic red;
	} sie_led_s;
endpackage : sie_pkg

// >>> sie_pattern_gen.sv
// Purpose: Shared timebase for blink, flash, flicker and colour-cycle patterns.
// Assumes: Pattern frame of forty units; one unit is UNIT_CYCLES clocks.
// Notes: All indicators share it, so patterns on different LEDs stay in step.
`timescale 1ns/1ns
`include "sie_map.svh"
module sie_pattern_gen
	import sie_pkg::*;
#(
	parameter int UNIT_CYCLES = `SIE_UNIT_CYC
)(
	input wire logic i_clock,
	input wire logic i_rst,
	output sie_pat_s o_pat
);
	logic [31:0] cyc_q;
	logic [5:0] ph_q;
	logic flick_q;
	logic [1:0] col_q;
	logic tick;

	if (UNIT_CYCLES < 1)
	begin : g_bad_unit
		$error("UNIT_CYCLES must be at least one");
	end

	assign tick = (cyc_q == 32'(UNIT_CYCLES - 1));

	always_ff @(posedge i_clock)
	begin
		if (i_rst || tick) cyc_q <= '0;
		else cyc_q <= cyc_q + 32'h1;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst) ph_q <= '0;
		else if (tick) ph_q <= (ph_q == `SIE_FRAME_LAST) ? 6'h0 : ph_q + 6'h1;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst) flick_q <= 1'b0;
		else if (tick) flick_q <= ~flick_q;
	end

	// Colour phase steps once per blink period: red, orange, green.
	always_ff @(posedge i_clock)
	begin
		if (i_rst) col_q <= '0;
		else if (tick && ph_q[`SIE_BLINK_BIT:0] == 3'h7)
			col_q <= (col_q == `SIE_COL_LAST) ? 2'h0 : col_q + 2'h1;
	end

	always_comb
	begin
		o_pat.tick = tick;
		o_pat.blink = ~ph_q[`SIE_BLINK_BIT];
		o_pat.single = ph_q < `SIE_FLASH_LEN;
		o_pat.dbl = o_pat.single || (ph_q >= `SIE_FLASH2_AT && ph_q < `SIE_FLASH2_AT + `SIE_FLASH_LEN);
		o_pat.triple = o_pat.dbl || (ph_q >= `SIE_FLASH3_AT && ph_q < `SIE_FLASH3_AT + `SIE_FLASH_LEN);
		o_pat.flicker = flick_q;
		o_pat.colour = col_q;
	end
endmodule : sie_pattern_gen

// >>> sie_indicator_top.sv
// Purpose: Front-panel status indicator encoder with APB register slave.
// Assumes: Status inputs come from same-clock logic; the button is an asynchronous pin.
// Notes: Summary of operation below.
// Summary of operation
// - Per-string bicolour LED: green run, red error.
// - Green shows slave state by pattern.
// - Red shows error class by pattern.
// - Port LED: on link, flicker traffic, off closed.
// - Manual-open closed port with link: inverted double flash.
// - No link, local negotiation error: single flash.
// - No link, remote negotiation error: double flash.
// - No link, unknown negotiation error: triple flash.
// - Display shows status, fault F/E, warning n.
// - Short button press scrolls network address.
// - Per-axis drive LED in red, green, orange.
// - Drive LED colours and blinks per drive state.
// - Per-axis local fieldbus bicolour LED, same encoding.
// - Service port link and activity LEDs.
`timescale 1ns/1ns
`include "sie_map.svh"
module sie_indicator_top
	import sie_pkg::*;
#(
	parameter int NUM_STRINGS = 2,
	parameter int NUM_PORTS = 2,
	parameter int NUM_AXES = 2,
	parameter int UNIT_CYCLES = `SIE_UNIT_CYC
)(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_irq,
	input sie_bus_state_s [NUM_STRINGS-1:0] i_string_state,
	input sie_bus_state_s [NUM_AXES-1:0] i_axis_bus_state,
	input sie_port_s [NUM_PORTS-1:0] i_port,
	input sie_drive_e [NUM_AXES-1:0] i_drive,
	input sie_code_s i_code,
	input wire logic [3:0] i_drive_status,
	input wire logic i_service_link,
	input wire logic i_service_act,
	input wire logic i_address_show_button,
	output sie_led_s [NUM_STRINGS-1:0] o_string_led,
	output sie_led_s [NUM_AXES-1:0] o_axis_bus_led,
	output logic [NUM_PORTS-1:0] o_port_led,
	output sie_led_s [NUM_AXES-1:0] o_drive_led,
	output logic [6:0] o_seg,
	output logic o_seg_dp,
	output logic o_service_link_led,
	output logic o_service_act_led
);
	sie_pat_s pat;
	logic [31:0] ctrl_q;
	logic [31:0] addr_q;
	logic [`SIE_IRQ_W-1:0] stat_q;
	logic [`SIE_IRQ_W-1:0] mask_q;
	logic [2:0] btn_sync_q;
	logic btn_q;
	logic [5:0] press_q;
	logic short_press;
	sie_disp_e disp_q;
	logic [3:0] idx_q;
	logic [4:0] char_q;
	logic code_valid_q;
	logic [NUM_PORTS-1:0] link_q;
	logic [`SIE_IRQ_W-1:0] events;
	logic wr;
	logic rd;
	logic char_end;
	logic en;
	sie_led_s [NUM_STRINGS-1:0] string_d;
	sie_led_s [NUM_AXES-1:0] axis_bus_d;
	sie_led_s [NUM_AXES-1:0] drive_d;
	logic [NUM_PORTS-1:0] port_d;
	logic [6:0] seg_d;
	logic dp_d;

	if (NUM_STRINGS < 1 || NUM_PORTS < 1 || NUM_AXES < 1)
	begin : g_bad_counts
		$error("Counts must be at least one");
	end

	function automatic logic run_green(input sie_run_e r, input sie_pat_s p);
		unique case (r)
			SIE_RUN_INIT: run_green = 1'b0;
			SIE_RUN_PREOP: run_green = p.blink;
			SIE_RUN_SAFEOP: run_green = p.single;
			SIE_RUN_OP: run_green = 1'b1;
			SIE_RUN_BOOT: run_green = p.flicker;
			default: run_green = 1'b0;
		endcase
	endfunction : run_green

	// Reserved and illegal error codes fall back to steady red so they are never hidden.
	function automatic logic err_red(input sie_err_e e, input sie_pat_s p);
		unique case (e)
			SIE_ERR_NONE: err_red = 1'b0;
			SIE_ERR_APP: err_red = 1'b1;
			SIE_ERR_WDOG: err_red = p.dbl;
			SIE_ERR_LOCAL: err_red = p.single;
			SIE_ERR_CFG: err_red = p.blink;
			SIE_ERR_BOOT: err_red = p.flicker;
			default: err_red = 1'b1;
		endcase
	endfunction : err_red

	function automatic sie_led_s bicolour(input sie_bus_state_s s, input sie_pat_s p);
		bicolour.green = run_green(s.run, p);
		bicolour.red = err_red(s.err, p);
	endfunction : bicolour

	function automatic logic [6:0] hex_seg(input logic [3:0] n);
		logic [6:0] s;
		s = `SIE_SEG_BLANK;
		unique case (n)
			4'h0: s = 7'h3f;
			4'h1: s = 7'h06;
			4'h2: s = 7'h5b;
			4'h3: s = 7'h4f;
			4'h4: s = 7'h66;
			4'h5: s = 7'h6d;
			4'h6: s = 7'h7d;
			4'h7: s = 7'h07;
			4'h8: s = 7'h7f;
			4'h9: s = 7'h6f;
			4'ha: s = 7'h77;
			4'hb: s = 7'h7c;
			4'hc: s = 7'h39;
			4'hd: s = 7'h5e;
			4'he: s = 7'h79;
			4'hf: s = 7'h71;
		endcase
		return s;
	endfunction : hex_seg

	sie_pattern_gen #(
		.UNIT_CYCLES(UNIT_CYCLES)
	) u_pattern (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.o_pat(pat)
	);

	assign en = ctrl_q[`SIE_CTRL_EN];

	// APB slave answers in the access cycle with no wait states.
	assign wr = i_psel && i_penable && i_pwrite;
	assign rd = i_psel && i_penable && !i_pwrite;
	assign o_pready = 1'b1;

	always_comb
	begin
		o_pslverr = 1'b0;
		o_prdata = '0;
		if (rd || wr)
		begin
			unique case (i_paddr)
				`SIE_OFF_CTRL: o_prdata = ctrl_q;
				`SIE_OFF_ADDR: o_prdata = addr_q;
				`SIE_OFF_IRQ_STAT: o_prdata = {{(32-`SIE_IRQ_W){1'b0}}, stat_q};
				`SIE_OFF_IRQ_MASK: o_prdata = {{(32-`SIE_IRQ_W){1'b0}}, mask_q};
				`SIE_OFF_STATE: o_prdata = {{(32-7){1'b0}}, idx_q, disp_q};
				default: o_pslverr = 1'b1;
			endcase
			if (!rd) o_prdata = '0;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst) ctrl_q <= `SIE_CTRL_RST;
		else if (wr && i_paddr == `SIE_OFF_CTRL) ctrl_q <= i_pwdata;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst) addr_q <= '0;
		else if (wr && i_paddr == `SIE_OFF_ADDR) addr_q <= i_pwdata;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst) mask_q <= '0;
		else if (wr && i_paddr == `SIE_OFF_IRQ_MASK) mask_q <= i_pwdata[`SIE_IRQ_W-1:0];
	end

	// A new event in the clearing cycle survives the write-one-to-clear.
	always_ff @(posedge i_clock)
	begin
		if (i_rst) stat_q <= '0;
		else if (wr && i_paddr == `SIE_OFF_IRQ_STAT)
			stat_q <= (stat_q & ~i_pwdata[`SIE_IRQ_W-1:0]) | events;
		else stat_q <= stat_q | events;
	end

	assign o_irq = |(stat_q & mask_q);

	always_comb
	begin
		events = '0;
		events[`SIE_IRQ_BTN] = short_press;
		events[`SIE_IRQ_FAULT] = i_code.valid && !code_valid_q;
		events[`SIE_IRQ_LINK] = |(link_q ^ port_links());
	end

	function automatic logic [NUM_PORTS-1:0] port_links();
		for (int i = 0; i < NUM_PORTS; i++) port_links[i] = i_port[i].link;
	endfunction : port_links

	always_ff @(posedge i_clock)
	begin
		if (i_rst) link_q <= '0;
		else link_q <= port_links();
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst) code_valid_q <= 1'b0;
		else code_valid_q <= i_code.valid;
	end

	// The button pin settles through three flops; a change counts when the last two agree.
	always_ff @(posedge i_clock)
	begin
		if (i_rst) btn_sync_q <= '0;
		else btn_sync_q <= {btn_sync_q[1:0], i_address_show_button};
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst) btn_q <= 1'b0;
		else if (btn_sync_q[2] == btn_sync_q[1]) btn_q <= btn_sync_q[2];
	end

	// Press length is counted in pattern units and saturates, so a long hold never scrolls.
	always_ff @(posedge i_clock)
	begin
		if (i_rst || !btn_q) press_q <= '0;
		else if (pat.tick && press_q != `SIE_LONG_UNITS) press_q <= press_q + 6'h1;
	end

	assign short_press = btn_q && btn_sync_q[2] == btn_sync_q[1] && !btn_sync_q[2]
		&& press_q != `SIE_LONG_UNITS;

	assign char_end = pat.tick && char_q == `SIE_CHAR_UNITS - 5'h1;

	always_ff @(posedge i_clock)
	begin
		if (i_rst || short_press || char_end) char_q <= '0;
		else if (pat.tick) char_q <= char_q + 5'h1;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			disp_q <= SIE_D_STATUS;
			idx_q <= '0;
		end
		else if (short_press)
		begin
			disp_q <= SIE_D_ADDR;
			idx_q <= '0;
		end
		else
		begin
			unique case (disp_q)
				SIE_D_STATUS:
					if (i_code.valid)
					begin
						disp_q <= SIE_D_CODE;
						idx_q <= '0;
					end
				SIE_D_CODE:
					if (!i_code.valid)
					begin
						disp_q <= SIE_D_STATUS;
						idx_q <= '0;
					end
					else if (char_end) idx_q <= (idx_q == `SIE_CODE_LAST) ? 4'h0 : idx_q + 4'h1;
				SIE_D_ADDR:
					if (char_end)
					begin
						if (idx_q == `SIE_ADDR_LAST)
						begin
							disp_q <= i_code.valid ? SIE_D_CODE : SIE_D_STATUS;
							idx_q <= '0;
						end
						else idx_q <= idx_q + 4'h1;
					end
				default:
				begin
					disp_q <= SIE_D_STATUS;
					idx_q <= '0;
				end
			endcase
		end
	end

	// Address nibble f is shown as the decimal point, the separator between fields.
	always_comb
	begin
		seg_d = `SIE_SEG_BLANK;
		dp_d = 1'b0;
		unique case (disp_q)
			SIE_D_STATUS: seg_d = hex_seg(i_drive_status);
			SIE_D_CODE:
				unique case (idx_q)
					4'h0: seg_d = i_code.warn ? `SIE_SEG_N : (i_code.use_e ? `SIE_SEG_E : `SIE_SEG_F);
					4'h1: seg_d = hex_seg(i_code.digits[11:8]);
					4'h2: seg_d = hex_seg(i_code.digits[7:4]);
					4'h3: seg_d = hex_seg(i_code.digits[3:0]);
					default: seg_d = `SIE_SEG_BLANK;
				endcase
			SIE_D_ADDR:
				if (idx_q != `SIE_ADDR_LAST)
				begin
					if (addr_q[(31 - 4 * idx_q) -: 4] == 4'hf) dp_d = 1'b1;
					else seg_d = hex_seg(addr_q[(31 - 4 * idx_q) -: 4]);
				end
			default: seg_d = `SIE_SEG_BLANK;
		endcase
	end

	always_comb
	begin
		for (int s = 0; s < NUM_STRINGS; s++) string_d[s] = bicolour(i_string_state[s], pat);
		for (int a = 0; a < NUM_AXES; a++)
		begin
			axis_bus_d[a] = bicolour(i_axis_bus_state[a], pat);
			unique case (i_drive[a])
				SIE_DRV_OFF: drive_d[a] = '0;
				SIE_DRV_RUN: drive_d[a] = '{green: 1'b1, red: 1'b0};
				SIE_DRV_WARN: drive_d[a] = '{green: 1'b1, red: pat.blink};
				SIE_DRV_SAFE: drive_d[a] = '{green: pat.blink, red: pat.blink};
				SIE_DRV_FAULT: drive_d[a] = '{green: pat.colour != 2'h0, red: pat.colour != 2'h2};
				default: drive_d[a] = '{green: 1'b0, red: 1'b1};
			endcase
		end
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			port_d[p] = 1'b0;
			if (i_port[p].cond == SIE_PC_MANUAL && i_port[p].link) port_d[p] = ~pat.dbl;
			else if (i_port[p].link) port_d[p] = i_port[p].act ? pat.flicker : 1'b1;
			else
				unique case (i_port[p].cond)
					SIE_PC_AN_LOCAL: port_d[p] = pat.single;
					SIE_PC_AN_REMOTE: port_d[p] = pat.dbl;
					SIE_PC_AN_UNKNOWN: port_d[p] = pat.triple;
					default: port_d[p] = 1'b0;
				endcase
		end
	end

	// Clearing the enable bit blanks the whole panel, which is handy for lamp tests.
	always_ff @(posedge i_clock)
	begin
		if (i_rst || !en)
		begin
			o_string_led <= '0;
			o_axis_bus_led <= '0;
			o_drive_led <= '0;
			o_port_led <= '0;
			o_seg <= `SIE_SEG_BLANK;
			o_seg_dp <= 1'b0;
			o_service_link_led <= 1'b0;
			o_service_act_led <= 1'b0;
		end
		else
		begin
			o_string_led <= string_d;
			o_axis_bus_led <= axis_bus_d;
			o_drive_led <= drive_d;
			o_port_led <= port_d;
			o_seg <= seg_d;
			o_seg_dp <= dp_d;
			o_service_link_led <= i_service_link;
			o_service_act_led <= i_service_act;
		end
	end
endmodule : sie_indicator_top

// >>> sie_indicator_chk.sv
// Purpose: Port checker for the indicator encoder.
// Assumes: Zero-wait APB slave; LED outputs registered one cycle after their cause.
// Notes: The enable bit is mirrored from APB writes, since the checker cannot read it.
`timescale 1ns/1ns
module sie_indicator_chk
	import sie_pkg::*;
#(
	parameter int NUM_STRINGS = 2,
	parameter int NUM_PORTS = 2,
	parameter int NUM_AXES = 2
)(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_irq,
	input sie_bus_state_s [NUM_STRINGS-1:0] i_string_state,
	input sie_port_s [NUM_PORTS-1:0] i_port,
	input sie_drive_e [NUM_AXES-1:0] i_drive,
	input wire logic i_service_link,
	input wire logic i_service_act,
	input sie_led_s [NUM_STRINGS-1:0] o_string_led,
	input wire logic [NUM_PORTS-1:0] o_port_led,
	input sie_led_s [NUM_AXES-1:0] o_drive_led,
	input wire logic [6:0] o_seg,
	input wire logic o_service_link_led,
	input wire logic o_service_act_led
);
	logic en_q, en_prev_q, rst_prev_q, svc_q, act_q, live, acc;
	sie_port_s p0_q;
	sie_bus_state_s s0_q;
	sie_drive_e d0_q;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	assign acc = i_psel && i_penable;
	assign live = !rst_prev_q && en_prev_q && en_q;
	always_ff @(posedge i_clock)
	begin
		rst_prev_q <= i_rst;
		en_prev_q <= en_q;
		svc_q <= i_service_link;
		act_q <= i_service_act;
		p0_q <= i_port[0];
		s0_q <= i_string_state[0];
		d0_q <= i_drive[0];
	end
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			en_q <= 1'b1;
		else if (acc && i_pwrite && i_paddr == 12'h000)
			en_q <= i_pwdata[0];
	end
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_access;
		i_psel && i_penable;
	endsequence
	a_access_ready: assert property (s_setup ##1 s_access |-> o_pready)
		else $error("access phase without ready");
	a_unmapped_err: assert property (acc && i_paddr > 12'h010 |-> o_pslverr && o_prdata == 32'h0)
		else $error("unmapped access not refused");
	a_mask_quiet: assert property (acc && i_pwrite && i_paddr == 12'h00c && i_pwdata[2:0] == 3'h0
		|=> !o_irq) else $error("interrupt with all sources masked");
	a_reset_dark: assert property ($fell(i_rst) |-> !o_irq && o_seg == 7'h00 && o_port_led == '0)
		else $error("outputs lit right after reset");
	a_service_follow: assert property (live |-> o_service_link_led == svc_q)
		else $error("service link lamp does not follow link");
	a_activity_follow: assert property (live |-> o_service_act_led == act_q)
		else $error("service activity lamp does not follow traffic");
	a_dark_disabled: assert property (!rst_prev_q && !en_prev_q && !en_q
		|-> o_port_led == '0 && o_seg == 7'h00 && !o_service_link_led) else $error("lit while off");
	a_port_steady: assert property (live && p0_q.link && !p0_q.act
		&& p0_q.cond == SIE_PC_OPEN |-> o_port_led[0])
		else $error("idle open port lamp not steady");
	a_port_closed: assert property (live && !p0_q.link && p0_q.cond == SIE_PC_CLOSED
		|-> !o_port_led[0]) else $error("closed port lamp lit");
	a_run_green: assert property (live && s0_q.run == SIE_RUN_OP
		|-> o_string_led[0].green) else $error("operational state not steady green");
	a_no_error_red: assert property (live && s0_q.err == SIE_ERR_NONE
		|-> !o_string_led[0].red) else $error("red lit without error");
	a_drive_green: assert property (live && d0_q == SIE_DRV_RUN
		|-> o_drive_led[0].green && !o_drive_led[0].red) else $error("running axis not green");
endmodule : sie_indicator_chk

// >>> sie_panel_model.sv
// Purpose: Front-panel model that counts lit cycles of eight lamps.
// Assumes: Lamps are sampled on the rising clock edge.
// Notes: A window of whole frames makes the count independent of pattern phase.
`timescale 1ns/1ns
module sie_panel_model #(
	parameter int WIN = 480
)(
	input wire logic i_clock,
	input wire logic i_start,
	input wire logic [7:0] i_lights,
	output logic o_done,
	output logic [7:0][9:0] o_cnt
);
	int left_q = 0;
	always_ff @(posedge i_clock)
	begin
		o_done <= 1'b0;
		if (i_start)
		begin
			o_cnt <= '0;
			left_q <= WIN;
		end
		else if (left_q > 0)
		begin
			for (int i = 0; i < 8; i++)
				o_cnt[i] <= o_cnt[i] + 10'(i_lights[i]);
			left_q <= left_q - 1;
			o_done <= (left_q == 1);
		end
	end
endmodule : sie_panel_model

// >>> testbench.sv
// Purpose: Self-checking bench for the indicator encoder.
// Assumes: UNIT_CYCLES of 4, so one pattern frame is 160 clocks.
// Notes: Lamp patterns are judged by lit cycles over three frames.
`timescale 1ns/1ns
`include "sie_map.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("unexpected %s exp=%0h got=%0h", nm, e, g); end end
module testbench
	import sie_pkg::*;
;
	localparam int UNIT = 4;
	localparam int WIN = 120 * UNIT;
	logic i_clock = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [11:0] i_paddr = '0;
	logic [31:0] i_pwdata = '0, o_prdata, rd, note;
	logic o_pready, o_pslverr, o_irq, o_seg_dp, o_service_link_led, o_service_act_led, er;
	sie_bus_state_s [1:0] i_string_state, i_axis_bus_state;
	sie_port_s [1:0] i_port;
	sie_drive_e [1:0] i_drive;
	sie_code_s i_code;
	logic [3:0] i_drive_status = '0;
	logic i_service_link = 1'b0, i_service_act = 1'b0, i_address_show_button;
	sie_led_s [1:0] o_string_led, o_axis_bus_led, o_drive_led;
	logic [1:0] o_port_led;
	logic [6:0] o_seg;
	logic start = 1'b0, done;
	logic [7:0] lights;
	logic [7:0][9:0] cnt;
	logic [31:0] notes[$];
	int failures = 0, samples_checked = 0, seed = 7;
	always #50 i_clock = ~i_clock;
	sie_indicator_top #(.UNIT_CYCLES(UNIT)) i_sie_indicator_top (.i_clock(i_clock), .i_rst(i_rst),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.o_irq(o_irq), .i_string_state(i_string_state), .i_axis_bus_state(i_axis_bus_state),
		.i_port(i_port), .i_drive(i_drive), .i_code(i_code), .i_drive_status(i_drive_status),
		.i_service_link(i_service_link), .i_service_act(i_service_act),
		.i_address_show_button(i_address_show_button), .o_string_led(o_string_led),
		.o_axis_bus_led(o_axis_bus_led), .o_port_led(o_port_led), .o_drive_led(o_drive_led),
		.o_seg(o_seg), .o_seg_dp(o_seg_dp), .o_service_link_led(o_service_link_led),
		.o_service_act_led(o_service_act_led));
	assign lights = {o_axis_bus_led[0], o_drive_led[0], o_port_led, o_string_led[0]};
	logic [5:0] unit0, unit1;
	assign unit0 = {o_string_led[0], o_drive_led[0], o_axis_bus_led[0]};
	assign unit1 = {o_string_led[1], o_drive_led[1], o_axis_bus_led[1]};
	sie_panel_model #(.WIN(WIN)) i_sie_panel_model (.i_clock(i_clock), .i_start(start),
		.i_lights(lights), .o_done(done), .o_cnt(cnt));
	// Lamp codes: 0 off, 1 on, 2 half, 3 single, 4 double, 5 triple, 6 inverted double, 7 two thirds.
	function automatic logic [9:0] cnt_of(input logic [3:0] c);
		case (c)
			4'h1: return 10'(WIN);
			4'h2: return 10'(WIN / 2);
			4'h3: return 10'(WIN / 10);
			4'h4: return 10'(WIN / 5);
			4'h5: return 10'(WIN * 3 / 10);
			4'h6: return 10'(WIN * 4 / 5);
			4'h7: return 10'(WIN * 2 / 3);
			default: return 10'h0;
		endcase
	endfunction : cnt_of
	always @(posedge i_clock)
	begin
		{i_service_link, i_service_act, i_drive_status} <= 6'($random(seed));
		if (done === 1'b1)
		begin
			note = notes.pop_front();
			for (int i = 0; i < 2; i++)
				`CHK("string", cnt_of(note[4*i+:4]), cnt[i])
			for (int i = 2; i < 4; i++)
				`CHK("port", cnt_of(note[4*i+:4]), cnt[i])
			for (int i = 4; i < 6; i++)
				`CHK("drive", cnt_of(note[4*i+:4]), cnt[i])
			for (int i = 6; i < 8; i++)
				`CHK("axis bus", cnt_of(note[4*i+:4]), cnt[i])
			`CHK("second unit", unit0, unit1)
		end
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clock);
		{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge i_clock);
		i_penable <= 1'b1;
		do
		begin
			@(posedge i_clock);
			{rd, er} = {o_prdata, o_pslverr};
			n++;
		end
		while (o_pready !== 1'b1 && n < 50);
		if (o_pready !== 1'b1) failures++;
		{i_psel, i_penable} <= 2'b00;
	endtask : apb
	task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("rdata", e, rd & m)
		`CHK("slverr", a > 12'h010, er)
	endtask : rchk
	task automatic measure(input logic [31:0] code);
		int n;
		notes.push_back(code);
		start <= 1'b1;
		@(posedge i_clock);
		start <= 1'b0;
		for (n = 0; done !== 1'b1 && n < WIN + 9; n++)
			@(posedge i_clock);
		if (done !== 1'b1) failures++;
		@(posedge i_clock);
	endtask : measure
	task automatic pcase(input sie_run_e r, input sie_err_e e, input sie_port_s p0,
		input sie_port_s p1, input sie_drive_e dv, input sie_bus_state_s ax, input logic [31:0] c);
		{i_string_state, i_port, i_drive, i_axis_bus_state} <= {r, e, r, e, p1, p0, dv, dv, ax, ax};
		repeat (3) @(posedge i_clock);
		measure(c);
	endtask : pcase
	task automatic wait_seg(input logic [7:0] e);
		for (int n = 0; {o_seg_dp, o_seg} !== e && n < 400; n++)
			@(negedge i_clock);
		`CHK("segments", e, {o_seg_dp, o_seg})
		@(posedge i_clock);
	endtask : wait_seg
	task automatic chk_irq(input logic e);
		@(negedge i_clock);
		`CHK("irq", e, o_irq)
	endtask : chk_irq
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	initial
	begin
		{i_string_state, i_axis_bus_state, i_port, i_drive, i_code} = '0;
		i_address_show_button = 1'b0;
		repeat (8) @(posedge i_clock);
		i_rst <= 1'b0;
		rchk(12'h000, 32'h1, 32'h1);
		rchk(12'h004, '1, 32'h0);
		rchk(12'h008, 32'h7, 32'h0);
		rchk(12'h00c, 32'h7, 32'h0);
		rchk(12'h010, 32'h7, 32'h1);
		rchk(12'h020, '1, 32'h0);
		apb(1'b1, 12'h00c, 32'h7);
		pcase(SIE_RUN_INIT, SIE_ERR_NONE, '{1, 0, SIE_PC_OPEN}, '{0, 0, SIE_PC_CLOSED},
			SIE_DRV_OFF, '{SIE_RUN_OP, SIE_ERR_APP}, 32'h1100_0100);
		pcase(SIE_RUN_PREOP, SIE_ERR_WDOG, '{1, 1, SIE_PC_OPEN}, '{0, 0, SIE_PC_AN_LOCAL},
			SIE_DRV_RUN, '{SIE_RUN_SAFEOP, SIE_ERR_LOCAL}, 32'h3310_3224);
		pcase(SIE_RUN_SAFEOP, SIE_ERR_LOCAL, '{1, 1, SIE_PC_MANUAL}, '{0, 0, SIE_PC_AN_REMOTE},
			SIE_DRV_WARN, '{SIE_RUN_BOOT, SIE_ERR_CFG}, 32'h2212_4633);
		pcase(SIE_RUN_OP, SIE_ERR_CFG, '{1, 0, SIE_PC_MANUAL}, '{0, 0, SIE_PC_AN_UNKNOWN},
			SIE_DRV_SAFE, '{SIE_RUN_INIT, SIE_ERR_BOOT}, 32'h0222_5612);
		pcase(SIE_RUN_BOOT, SIE_ERR_BOOT, '{0, 0, SIE_PC_CLOSED}, '{1, 1, SIE_PC_OPEN},
			SIE_DRV_FAULT, '{SIE_RUN_INIT, SIE_ERR_NONE}, 32'h0077_2022);
		rchk(12'h008, 32'h4, 32'h4);
		chk_irq(1'b1);
		apb(1'b1, 12'h008, 32'h4);
		chk_irq(1'b0);
		apb(1'b1, 12'h000, 32'h0);
		repeat (3) @(posedge i_clock);
		measure(32'h0);
		`CHK("seg off", 7'h00, o_seg)
		apb(1'b1, 12'h000, 32'h1);
		i_code <= '{1, 1, 0, 12'h123};
		wait_seg({1'b0, `SIE_SEG_N});
		i_code <= '{1, 0, 1, 12'h123};
		wait_seg({1'b0, `SIE_SEG_E});
		i_code <= '{1, 0, 0, 12'h123};
		wait_seg({1'b0, `SIE_SEG_F});
		wait_seg(8'h06);
		rchk(12'h008, 32'h2, 32'h2);
		apb(1'b1, 12'h004, 32'hf000_0000);
		apb(1'b1, 12'h008, 32'h7);
		i_address_show_button <= 1'b1;
		repeat (10 * UNIT) @(posedge i_clock);
		i_address_show_button <= 1'b0;
		wait_seg(8'h80);
		rchk(12'h010, 32'h7, 32'h4);
		rchk(12'h008, 32'h1, 32'h1);
		chk_irq(1'b1);
		apb(1'b1, 12'h00c, 32'h0);
		chk_irq(1'b0);
		wrap_up();
	end
	// The whole run needs about 3100 clocks; the limit leaves ample margin.
	initial
	begin
		#2000000;
		failures++;
		wrap_up();
	end
endmodule : testbench
bind sie_indicator_top sie_indicator_chk #(.NUM_STRINGS(NUM_STRINGS), .NUM_PORTS(NUM_PORTS),
	.NUM_AXES(NUM_AXES)) i_chk (.i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq),
	.i_string_state(i_string_state), .i_port(i_port), .i_drive(i_drive),
	.i_service_link(i_service_link), .i_service_act(i_service_act),
	.o_string_led(o_string_led), .o_port_led(o_port_led), .o_drive_led(o_drive_led),
	.o_seg(o_seg), .o_service_link_led(o_service_link_led),
	.o_service_act_led(o_service_act_led));
